// ---- hdl/xmbi_regs.svh ----
// constants of the external memory bus interface: address map, reset values, cycle counts
`ifndef XMBI_REGS_SVH
`define XMBI_REGS_SVH

// first external address, just above the internal sram
`define XMBI_EXT_BASE        16'h2100
// sector limit is the select value times 8 kbyte
`define XMBI_SECTOR_SHIFT    13
// select values below this give one upper sector only
`define XMBI_SECTOR_MIN_SEL  3'h2
// strobe length without wait-states
`define XMBI_STROBE_BASE     2'h1
// cycles after the strobe until synchronised read data is taken
`define XMBI_TAIL_CYCLES     2'h2
// value of every control field and latch after reset
`define XMBI_RST_CTRL        1'b0
`define XMBI_RST_BYTE        8'h00
`define XMBI_RST_ADDR        16'h0000
`define XMBI_RST_CNT         2'h0
`define XMBI_RST_REL         3'h0
`define XMBI_RST_KEEP        1'b0

`endif

// ---- hdl/xmbi_pkg.sv ----
// types of the external memory bus interface
package xmbi_pkg;

    // wait-state select of one sector
    typedef enum logic [1:0] {
        XMBI_WAIT_NONE,
        XMBI_WAIT_ONE,
        XMBI_WAIT_TWO,
        XMBI_WAIT_TWO_GAP
    } xmbi_wait_e;

    // bus cycle sequencer
    typedef enum logic [2:0] {
        XMBI_ST_IDLE,
        XMBI_ST_ADDR,
        XMBI_ST_HOLD,
        XMBI_ST_STRB,
        XMBI_ST_TAIL,
        XMBI_ST_GAP
    } xmbi_state_e;

endpackage : xmbi_pkg

// ---- hdl/xmbi_bus.sv ----
// external memory bus interface: multiplexed address/data bus, latch strobe, read and write strobes
`timescale 1ns/1ns
`include "xmbi_regs.svh"

// Notes on behaviour
// - with the interface enabled, addresses above internal sram go out on the external pins.
// - pins are muxed low address/data, high address bus, latch, read and write strobes.
// - while enabled, the interface overrides software direction settings of its pins.
// - each access is decoded internal or external; external ones drive address, data and strobes.
// - the low address byte is valid on the muxed bus when the latch strobe falls.
// - the latch strobe stays low during the whole data-transfer phase.
// - internal accesses while enabled may move address and latch, never read or write strobes.
// - when disabled, pins go back to normal port values and directions.
// - when disabled, addresses above internal sram never alias onto internal sram.
// - four wait-state settings are offered, one of them with no wait-state.
// - external space splits into two sectors of set size, each with its own wait setting.
// - the number of high address pins taken by the interface is selectable.
// - with the keeper on, the last driven muxed-bus value is held while the lines float.
// - a weak pull-up acts on each undriven muxed line whose port output bit is one.
// - wait codes: none, one strobe cycle, two strobe cycles, two plus one gap cycle.
// - with sector limit zero the whole range 0x2100 to 0xFFFF is one upper sector.
// - the bus keeper acts on its own enable, independent of the interface enable.
module xmbi_bus (
    input  wire logic                       clk,
    input  wire logic                       arst_n,
    // access request from the core
    input  wire logic                       req_valid,
    input  wire logic                       req_write,
    input  wire logic [15:0]                req_addr,
    input  wire logic [7:0]                 req_wdata,
    output logic                            req_done,
    output logic                            req_internal,
    output logic [7:0]                      req_rdata,
    // control bits
    input  wire logic                       interface_enable,
    input  wire logic [2:0]                 sector_limit_select,
    input  wire logic [1:0]                 wait_select_hi,
    input  wire logic [1:0]                 wait_select_lo,
    input  wire logic                       bus_keeper_enable,
    input  wire logic [2:0]                 high_addr_release,
    output logic                            busy,
    // normal port settings of the shared pins
    input  wire logic [7:0]                 port_out_ad,
    input  wire logic [7:0]                 port_dir_ad,
    input  wire logic [7:0]                 port_out_hi,
    input  wire logic [7:0]                 port_dir_hi,
    input  wire logic [2:0]                 port_out_ctl,
    input  wire logic [2:0]                 port_dir_ctl,
    // muxed low address / data bus
    input  wire logic [7:0]                 muxed_addr_data_bus_in,
    output logic [7:0]                      muxed_addr_data_bus_out,
    output logic [7:0]                      muxed_addr_data_bus_oe,
    output logic [7:0]                      muxed_pullup_en,
    output logic [7:0]                      muxed_keeper_en,
    output logic [7:0]                      muxed_keeper_val,
    output logic [7:0]                      port_in_ad,
    // high address bus
    output logic [7:0]                      high_address_bus_out,
    output logic [7:0]                      high_address_bus_oe,
    // strobes: index 0 latch, 1 read_n, 2 write_n
    output logic                            addr_latch_out,
    output logic                            addr_latch_oe,
    output logic                            rd_n_out,
    output logic                            rd_n_oe,
    output logic                            wr_n_out,
    output logic                            wr_n_oe
);
    import xmbi_pkg::*;

    // extra strobe cycles of a wait code
    function automatic logic [1:0] xmbi_extra(input xmbi_wait_e code);
        case (code)
            XMBI_WAIT_NONE: xmbi_extra = 2'h0;
            XMBI_WAIT_ONE:  xmbi_extra = 2'h1;
            default:        xmbi_extra = 2'h2;
        endcase
    endfunction : xmbi_extra

    xmbi_state_e state_ff;
    xmbi_state_e nxt_state;
    logic [15:0] addr_ff;
    logic [7:0]  wdata_ff;
    logic        write_ff;
    logic        ext_ff;
    xmbi_wait_e  wait_ff;
    logic [1:0]  cnt_ff;
    logic [1:0]  nxt_cnt;
    logic [7:0]  rdata_ff;
    logic        done_ff;
    logic        nxt_done;
    logic [7:0]  ad_sync1_ff;
    logic [7:0]  ad_sync2_ff;
    logic [7:0]  keep_ff;
    logic [2:0]  release_ff;

    // address decode
    wire         is_external  = req_addr >= `XMBI_EXT_BASE;
    wire [15:0]  sector_limit = 16'(sector_limit_select) << `XMBI_SECTOR_SHIFT;
    // select values below two keep the whole external range as the upper sector
    wire         two_sectors  = sector_limit_select >= `XMBI_SECTOR_MIN_SEL;
    wire         lower_sector = two_sectors && (req_addr < sector_limit);
    wire [1:0]   sel_wait     = lower_sector ? wait_select_lo : wait_select_hi;
    wire         take         = (state_ff == XMBI_ST_IDLE) && req_valid;
    wire         off_take     = take && !interface_enable;
    wire         to_bus       = interface_enable;
    wire         strobe_len_end = (cnt_ff == 2'h0);

    // pin activity per state
    wire         st_addr  = (state_ff == XMBI_ST_ADDR);
    wire         st_hold  = (state_ff == XMBI_ST_HOLD);
    wire         st_strb  = (state_ff == XMBI_ST_STRB);
    wire         st_tail  = (state_ff == XMBI_ST_TAIL);
    wire         in_cycle = st_addr || st_hold || st_strb || st_tail;
    wire         tail_last = st_tail && (cnt_ff == 2'h1);
    wire         ext_strb = st_strb && ext_ff;
    wire         rd_act   = ext_strb && !write_ff;
    wire         wr_act   = ext_strb && write_ff;
    // address stays on the muxed bus through the falling latch edge
    wire         drive_addr = st_addr || st_hold;
    // write data stays on through the tail, so the rising write strobe still sees it
    wire         drive_data = write_ff && ext_ff && (st_strb || st_tail);
    wire         rd_capture = tail_last && !write_ff;
    wire         xm_ad_oe   = drive_addr || drive_data;
    wire [7:0]   xm_ad_val  = drive_addr ? addr_ff[7:0] : wdata_ff;

    // sequencer
    always_comb begin
        nxt_state = state_ff;
        nxt_cnt   = cnt_ff;
        nxt_done  = 1'b0;
        case (state_ff)
            XMBI_ST_IDLE: begin
                if (req_valid) begin
                    if (to_bus) begin
                        nxt_state = XMBI_ST_ADDR;
                    end else begin
                        // disabled: no pin activity, external range reads as zero
                        nxt_done = 1'b1;
                    end
                end
            end
            XMBI_ST_ADDR: begin
                nxt_state = XMBI_ST_HOLD;
            end
            XMBI_ST_HOLD: begin
                if (ext_ff) begin
                    nxt_state = XMBI_ST_STRB;
                    nxt_cnt   = xmbi_extra(wait_ff);
                end else begin
                    nxt_state = XMBI_ST_IDLE;
                    nxt_done  = 1'b1;
                end
            end
            XMBI_ST_STRB: begin
                if (strobe_len_end) begin
                    nxt_state = XMBI_ST_TAIL;
                    nxt_cnt   = `XMBI_TAIL_CYCLES;
                end else begin
                    nxt_cnt = cnt_ff - 2'h1;
                end
            end
            XMBI_ST_TAIL: begin
                if (tail_last) begin
                    if (wait_ff == XMBI_WAIT_TWO_GAP) begin
                        nxt_state = XMBI_ST_GAP;
                    end else begin
                        nxt_state = XMBI_ST_IDLE;
                        nxt_done  = 1'b1;
                    end
                end
                nxt_cnt = cnt_ff - 2'h1;
            end
            XMBI_ST_GAP: begin
                nxt_state = XMBI_ST_IDLE;
                nxt_done  = 1'b1;
            end
            default: begin
                nxt_state = XMBI_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state_ff <= XMBI_ST_IDLE;
            cnt_ff   <= `XMBI_RST_CNT;
            done_ff  <= `XMBI_RST_CTRL;
        end else begin
            state_ff <= nxt_state;
            cnt_ff   <= nxt_cnt;
            done_ff  <= nxt_done;
        end
    end

    // request capture; settings are frozen for the whole bus cycle
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            addr_ff    <= `XMBI_RST_ADDR;
            wdata_ff   <= `XMBI_RST_BYTE;
            write_ff   <= `XMBI_RST_CTRL;
            ext_ff     <= `XMBI_RST_CTRL;
            wait_ff    <= XMBI_WAIT_NONE;
            release_ff <= `XMBI_RST_REL;
        end else if (take) begin
            addr_ff    <= req_addr;
            wdata_ff   <= req_wdata;
            write_ff   <= req_write;
            ext_ff     <= is_external;
            wait_ff    <= xmbi_wait_e'(sel_wait);
            release_ff <= high_addr_release;
        end
    end

    // read data: taken from the synchronised bus two cycles after the strobe rises
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rdata_ff <= `XMBI_RST_BYTE;
        end else if (off_take) begin
            rdata_ff <= `XMBI_RST_BYTE;
        end else if (rd_capture) begin
            rdata_ff <= ext_ff ? ad_sync2_ff : `XMBI_RST_BYTE;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ad_sync1_ff <= `XMBI_RST_BYTE;
            ad_sync2_ff <= `XMBI_RST_BYTE;
        end else begin
            ad_sync1_ff <= muxed_addr_data_bus_in;
            ad_sync2_ff <= ad_sync1_ff;
        end
    end

    // final pin drive, before the keeper takes a copy
    logic [7:0] ad_out_w;
    logic [7:0] ad_oe_w;
    assign ad_out_w = to_bus ? xm_ad_val : port_out_ad;
    assign ad_oe_w  = to_bus ? {8{xm_ad_oe}} : port_dir_ad;

    // keeper remembers the last value driven on each line
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_keep
            always_ff @(posedge clk or negedge arst_n) begin
                if (!arst_n) begin
                    keep_ff[gi] <= `XMBI_RST_KEEP;
                end else if (ad_oe_w[gi]) begin
                    keep_ff[gi] <= ad_out_w[gi];
                end
            end
        end
    endgenerate

    // high address pins: the top release_ff pins stay with the port
    logic [7:0] hi_owned;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_hi
            assign hi_owned[gi] = to_bus && ({1'b0, release_ff} < 4'(8 - gi));
        end
    endgenerate

    assign high_address_bus_out = (hi_owned & addr_ff[15:8]) | (~hi_owned & port_out_hi);
    assign high_address_bus_oe  = hi_owned | (~hi_owned & port_dir_hi);

    assign muxed_addr_data_bus_out = ad_out_w;
    assign muxed_addr_data_bus_oe  = ad_oe_w;
    assign muxed_pullup_en         = port_out_ad & ~ad_oe_w;
    assign muxed_keeper_en         = {8{bus_keeper_enable}} & ~ad_oe_w;
    assign muxed_keeper_val        = keep_ff;
    assign port_in_ad              = ad_sync2_ff;

    // strobe pins, index 0 latch, 1 read, 2 write
    // latch high from address phase; low through hold, strobe and tail
    logic [2:0] xm_ctl_val;
    logic [2:0] ctl_out_w;
    logic [2:0] ctl_oe_w;
    assign xm_ctl_val = {!wr_act, !rd_act, st_addr};
    generate
        for (gi = 0; gi < 3; gi++) begin : g_ctl
            assign ctl_out_w[gi] = to_bus ? xm_ctl_val[gi] : port_out_ctl[gi];
            assign ctl_oe_w[gi]  = to_bus || port_dir_ctl[gi];
        end
    endgenerate

    assign addr_latch_out = ctl_out_w[0];
    assign addr_latch_oe  = ctl_oe_w[0];
    assign rd_n_out       = ctl_out_w[1];
    assign rd_n_oe        = ctl_oe_w[1];
    assign wr_n_out       = ctl_out_w[2];
    assign wr_n_oe        = ctl_oe_w[2];

    assign req_done     = done_ff;
    assign req_rdata    = rdata_ff;
    assign req_internal = !is_external;
    assign busy         = in_cycle || (state_ff == XMBI_ST_GAP);

endmodule : xmbi_bus

// ---- verification/xmbi_bus_sva.sv ----
// checker of the external memory bus interface
`timescale 1ns/1ns
module xmbi_bus_sva (
    input wire logic       clk,
    input wire logic       arst_n,
    input wire logic       req_valid,
    input wire logic [15:0] req_addr,
    input wire logic       req_done,
    input wire logic       req_internal,
    input wire logic       interface_enable,
    input wire logic [2:0] sector_limit_select,
    input wire logic [1:0] wait_select_hi,
    input wire logic       bus_keeper_enable,
    input wire logic [2:0] high_addr_release,
    input wire logic       busy,
    input wire logic [7:0] port_out_ad,
    input wire logic [7:0] port_dir_ad,
    input wire logic [7:0] port_dir_hi,
    input wire logic [7:0] muxed_addr_data_bus_out,
    input wire logic [7:0] muxed_addr_data_bus_oe,
    input wire logic [7:0] muxed_pullup_en,
    input wire logic [7:0] muxed_keeper_en,
    input wire logic [7:0] high_address_bus_oe,
    input wire logic       addr_latch_out,
    input wire logic       addr_latch_oe,
    input wire logic       rd_n_out,
    input wire logic       rd_n_oe,
    input wire logic       wr_n_out,
    input wire logic       wr_n_oe
);
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);
    wire take = req_valid && !busy && interface_enable && !req_internal;
    wire upper = take && sector_limit_select < 3'h2;
    sequence s_done_6; !req_done [*5] ##1 req_done; endsequence
    sequence s_done_9; !req_done [*8] ##1 req_done; endsequence
    a_no_wait_len: assert property (upper && wait_select_hi == 2'h0 |=> s_done_6)
        else $error("no-wait access finished at the wrong cycle");
    a_gap_wait_len: assert property (upper && wait_select_hi == 2'h3 |=> s_done_9)
        else $error("longest wait access finished at the wrong cycle");
    a_internal_no_strobe: assert property (req_valid && !busy && req_internal && interface_enable
        |=> (rd_n_out && wr_n_out) [*3]) else $error("strobe moved on internal access");
    a_off_done_next: assert property (req_valid && !busy && !interface_enable |=> req_done)
        else $error("disabled access not finished in one cycle");
    a_strobe_idle_high: assert property (interface_enable && !busy |-> rd_n_out && wr_n_out)
        else $error("strobe low outside a bus cycle");
    a_one_strobe: assert property (interface_enable |-> rd_n_out || wr_n_out)
        else $error("read and write strobes low together");
    a_pins_owned: assert property (interface_enable |-> rd_n_oe && wr_n_oe && addr_latch_oe)
        else $error("enabled interface not driving its strobes");
    a_pins_to_port: assert property (!interface_enable |-> muxed_addr_data_bus_oe == port_dir_ad
        && muxed_addr_data_bus_out == port_out_ad) else $error("disabled bus not following port");
    a_addr_at_fall: assert property ($fell(addr_latch_out) && interface_enable && busy
        |-> muxed_addr_data_bus_oe == 8'hFF && muxed_addr_data_bus_out == req_addr[7:0])
        else $error("no valid low address at latch fall");
    a_latch_low_xfer: assert property (interface_enable && !(rd_n_out && wr_n_out) |-> !addr_latch_out)
        else $error("latch strobe high during transfer");
    a_high_pins_owned: assert property (interface_enable && !rd_n_out
        |-> high_address_bus_oe == (port_dir_hi | (8'hFF >> high_addr_release)))
        else $error("wrong set of high address pins driven");
    a_pullup_lines: assert property (muxed_pullup_en == (port_out_ad & ~muxed_addr_data_bus_oe))
        else $error("pull-up enables wrong");
    a_keeper_lines: assert property (muxed_keeper_en == ({8{bus_keeper_enable}} & ~muxed_addr_data_bus_oe))
        else $error("keeper enables wrong");
endmodule : xmbi_bus_sva

bind xmbi_bus xmbi_bus_sva i_sva (.*);

// ---- verification/xmbi_sram_model.sv ----
// external sram model behind a transparent address latch
`timescale 1ns/1ns
module xmbi_sram_model #(parameter int ACC_NS = 4) (
    input wire logic       [7:0] pin,
    input wire logic             latch,
    input wire logic             rd_n,
    input wire logic             wr_n,
    output logic                 drv,
    output logic           [7:0] rdata
);
    logic [7:0] mem [0:255];
    logic [7:0] lat_q = 8'h00;
    always @* if (latch) lat_q = pin;
    always @(posedge wr_n) mem[lat_q] <= pin;
    // data appears and leaves one access time after the read strobe moves
    assign #ACC_NS drv = !rd_n;
    assign rdata = mem[lat_q];
endmodule : xmbi_sram_model

// ---- verification/test_xmbi_bus.sv ----
// testbench of the external memory bus interface
`timescale 1ns/1ns
module test_xmbi_bus;
    logic clk = 1'b0, arst_n = 1'b0, req_valid = 1'b0, req_write = 1'b0;
    logic interface_enable = 1'b0, bus_keeper_enable = 1'b0;
    logic [15:0] req_addr = 16'h0000;
    logic [7:0] req_wdata = 8'h00, port_out_ad = 8'h00, port_dir_ad = 8'h00, port_out_hi = 8'h00, port_dir_hi = 8'h00;
    logic [2:0] sector_limit_select = 3'h0, high_addr_release = 3'h0, port_out_ctl = 3'h6, port_dir_ctl = 3'h0;
    logic [1:0] wait_select_hi = 2'h0, wait_select_lo = 2'h0;
    logic req_done, req_internal, busy, addr_latch_out, addr_latch_oe, rd_n_out, rd_n_oe, wr_n_out, wr_n_oe;
    logic [7:0] req_rdata, muxed_addr_data_bus_out, muxed_addr_data_bus_oe, muxed_pullup_en, muxed_keeper_en;
    logic [7:0] muxed_keeper_val, port_in_ad, high_address_bus_out, high_address_bus_oe, mem_q;
    logic [7:0] float_q = 8'h00;
    logic mem_drv;
    int checks = 0, mismatches = 0, n;
    wire [7:0] muxed_addr_data_bus_in;
    // released lines float to a changing pattern
    assign muxed_addr_data_bus_in = (muxed_addr_data_bus_out & muxed_addr_data_bus_oe)
        | (~muxed_addr_data_bus_oe & (mem_drv ? mem_q : float_q));
    always @(posedge clk) float_q <= ~muxed_addr_data_bus_in;
    xmbi_bus i_dut (.*);
    xmbi_sram_model i_mem (.pin(muxed_addr_data_bus_in), .latch(addr_latch_out), .rd_n(rd_n_out),
        .wr_n(wr_n_out), .drv(mem_drv), .rdata(mem_q));
    initial begin
        forever #10 clk = ~clk;
    end
    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    // one access; n counts edges from raising the request to seeing done
    task automatic acc(input logic wr, input logic [15:0] a, input logic [7:0] d, output int n);
        n = 0;
        req_write = wr;
        req_addr = a;
        req_wdata = d;
        req_valid = 1'b1;
        do begin
            @(posedge clk);
            #1;
            n++;
        end while (req_done !== 1'b1 && n < 50);
        req_valid = 1'b0;
        @(posedge clk);
        #1;
    endtask : acc
    task automatic t_reset();
        chk("req_done", req_done, 1'b0);
        chk("req_rdata", req_rdata, 8'h00);
        chk("rd_n_oe", rd_n_oe, port_dir_ctl[1]);
    endtask : t_reset
    task automatic t_disabled();
        acc(1'b1, 16'h9000, 8'h5A, n);
        chk("off write length", n, 1);
        acc(1'b0, 16'h9000, 8'h00, n);
        chk("off read data", req_rdata, 8'h00);
    endtask : t_disabled
    task automatic t_waits();
        interface_enable = 1'b1;
        for (int c = 0; c < 4; c++) begin
            wait_select_hi = 2'(c);
            high_addr_release = 3'(c);
            acc(1'b1, 16'h8000 + 16'(c), 8'hA0 + 8'(c), n);
            chk("write length", n, 6 + c);
            chk("high pins driven", high_address_bus_oe, 8'hFF >> c);
            chk("high address", high_address_bus_out, 8'h80 & (8'hFF >> c));
            acc(1'b0, 16'h8000 + 16'(c), 8'h00, n);
            chk("read length", n, 6 + c);
            chk("read data", req_rdata, 8'hA0 + 8'(c));
        end
        high_addr_release = 3'h0;
    endtask : t_waits
    task automatic t_sectors();
        logic [2:0] sel [4] = '{3'h4, 3'h4, 3'h4, 3'h1};
        logic [15:0] adr [4] = '{16'h2100, 16'h7FFF, 16'h8000, 16'h2100};
        int ex [4] = '{9, 9, 6, 6};
        wait_select_lo = 2'h3;
        wait_select_hi = 2'h0;
        for (int i = 0; i < 4; i++) begin
            sector_limit_select = sel[i];
            acc(1'b1, adr[i], 8'h30 + 8'(i), n);
            chk("sector length", n, ex[i]);
            acc(1'b0, adr[i], 8'h00, n);
            chk("sector data", req_rdata, 8'h30 + 8'(i));
        end
        sector_limit_select = 3'h0;
    endtask : t_sectors
    task automatic t_internal();
        acc(1'b0, 16'h20FF, 8'h00, n);
        chk("internal length", n, 3);
        chk("internal flag", req_internal, 1'b1);
        req_addr = 16'h2100;
        @(posedge clk);
        #1;
        chk("external flag", req_internal, 1'b0);
    endtask : t_internal
    // reset in the middle of an external read
    task automatic t_midreset();
        req_write = 1'b0;
        req_addr = 16'h8000;
        req_valid = 1'b1;
        repeat (3) @(posedge clk);
        #1;
        chk("strobe before reset", rd_n_out, 1'b0);
        arst_n = 1'b0;
        req_valid = 1'b0;
        #1;
        chk("busy in reset", busy, 1'b0);
        chk("read strobe in reset", rd_n_out, 1'b1);
        chk("read data in reset", req_rdata, 8'h00);
        repeat (2) @(posedge clk);
        #1;
        arst_n = 1'b1;
        @(posedge clk);
        #1;
        chk("done after reset", req_done, 1'b0);
        chk("busy after reset", busy, 1'b0);
    endtask : t_midreset
    task automatic t_keep();
        acc(1'b0, 16'h8001, 8'h00, n);
        chk("read before off", req_rdata, 8'hA1);
        interface_enable = 1'b0;
        bus_keeper_enable = 1'b1;
        port_out_ad = 8'h3F;
        port_dir_ad = 8'h30;
        @(posedge clk);
        #1;
        chk("keeper enables", muxed_keeper_en, 8'hCF);
        chk("pull-up enables", muxed_pullup_en, 8'h0F);
        acc(1'b0, 16'h8001, 8'h00, n);
        chk("off read after on", req_rdata, 8'h00);
        port_dir_ad = 8'hFF;
        repeat (3) @(posedge clk);
        #1;
        chk("port input", port_in_ad, 8'h3F);
        port_dir_ad = 8'h00;
        interface_enable = 1'b1;
        acc(1'b1, 16'hC001, 8'h66, n);
        chk("kept value", muxed_keeper_val, 8'h66);
        chk("keeper when idle", muxed_keeper_en, 8'hFF);
    endtask : t_keep
    task automatic final_report();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : final_report
    initial begin
        #60000;
        mismatches++;
        final_report();
    end
    initial begin
        repeat (12) @(posedge clk);
        #1;
        arst_n = 1'b1;
        t_reset();
        t_disabled();
        t_waits();
        t_sectors();
        t_midreset();
        t_internal();
        t_keep();
        final_report();
    end
endmodule : test_xmbi_bus
